//--- sdram_pattern_tester_test.sv
// sdram_pattern_tester_test: self-checking bench of the pattern tester
`default_nettype none

module sdram_pattern_tester_test;
  timeunit 1ns;
  timeprecision 1ps;
  import sdt_pkg::*;

  localparam int unsigned TW = 16;
  localparam int unsigned BC = 4;

  logic         clk;
  logic         srst;
  logic         btn_n;
  logic         lock;
  logic         mready;
  logic         irq;
  logic         slow;
  logic         bad_en;
  logic         err_v;
  logic         req_seen;
  logic [2:0]   leds;
  logic [2:0]   leds_q;
  logic [31:0]  rd_v;
  sdt_apb_req_t apb_q;
  sdt_apb_rsp_t apb_rsp;
  sdt_mem_req_t mreq;
  sdt_mem_rsp_t mrsp;
  int           err_count;
  int           compares;
  int           beats;
  int           passes;

  sdt_tester #(.TEST_WORDS(TW), .BLINK_CYC(BC)) u_dut (
    .I_CLOCK(clk), .I_SRST(srst), .I_START_BUTTON_N(btn_n),
    .I_APB(apb_q), .O_APB(apb_rsp), .I_MEM_CLK_LOCKED(lock),
    .O_MEM_REQ(mreq), .I_MEM_READY(mready), .I_MEM_RSP(mrsp),
    .O_RED_INDICATORS(leds), .O_IRQ(irq));

  sdt_mem_model #(.WORDS(TW)) u_mem (
    .i_clock(clk), .i_srst(srst), .i_slow(slow), .i_bad_en(bad_en),
    .i_bad_addr(25'h5), .i_req(mreq), .o_ready(mready), .o_rsp(mrsp));

  always #25 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  // sampled on the falling edge so registered outputs have settled
  always @(negedge clk) begin
    leds_q <= leds;
    if (leds[2] !== leds_q[2]) beats++;
    if (leds[1] !== leds_q[1]) passes++;
    if (!lock && mreq.req) req_seen = 1'b1;
  end

  function automatic logic [15:0] pat(input logic [24:0] a);
    return a[15:0] ^ {a[8:0], a[24:18]} ^ SEED_RST;
  endfunction : pat

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge clk);
    apb_q <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
    @(posedge clk);
    apb_q.penable <= 1'b1;
    do @(posedge clk); while (apb_rsp.pready !== 1'b1);
    rd_v  = apb_rsp.prdata;
    err_v = apb_rsp.pslverr;
    apb_q.psel    <= 1'b0;
    apb_q.penable <= 1'b0;
  endtask : apb

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd_v, exp);
  endtask : rd_chk

  task automatic press();
    @(posedge clk) btn_n <= 1'b0;
    repeat (3) @(posedge clk);
    check(32'(leds), 32'h7);
    btn_n <= 1'b1;
  endtask : press

  task automatic wait_done();
    do apb(1'b0, OFS_STATUS, 32'h0); while (rd_v[2:0] !== 3'h4);
    @(negedge clk);
  endtask : wait_done

  task automatic print_verdict();
    $display("compares %0d err_count %0d", compares, err_count);
    if ((err_count == 0) && (compares > 0)) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict

  ////////////////////////////////////////////////////////////////////////////
  // five short runs take well under 2000 cycles; allow ten times that
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    print_verdict();
  end

  initial begin
    clk = 1'b0; srst = 1'b1; btn_n = 1'b1; lock = 1'b0; slow = 1'b0;
    bad_en = 1'b0; apb_q = '0; req_seen = 1'b0; leds_q = '0;
    err_count = 0; compares = 0; beats = 0; passes = 0;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    check(32'(leds[1:0]), 32'h0);
    rd_chk(OFS_SEED, 32'h5A3C);
    rd_chk(OFS_STATUS, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    check(32'(err_v), 32'h1);
    check(rd_v, 32'h0);
    apb(1'b1, OFS_IRQ_MASK, 32'h1);
    // memory clock not yet locked: engine must wait with no traffic
    press();
    repeat (20) @(posedge clk);
    rd_chk(OFS_STATUS, 32'h2);
    check(32'(req_seen), 32'h0);
    lock <= 1'b1;
    wait_done();
    check(32'(beats > 4), 32'h1);
    check(32'(passes > 3), 32'h1);
    check(32'(leds[1:0]), 32'h2);
    repeat (12) @(negedge clk);
    check(32'(leds[1:0]), 32'h2);
    rd_chk(OFS_STATUS, 32'h34);
    for (int i = 0; i < TW; i++) begin
      check(32'(u_mem.mem[i]), 32'(pat(25'(i))));
    end
    check(32'(u_mem.writes), TW);
    check(32'(u_mem.reads), TW);
    rd_chk(OFS_IRQ_STAT, 32'h1);
    check(32'(irq), 32'h1);
    apb(1'b1, OFS_IRQ_STAT, 32'h1);
    @(negedge clk);
    check(32'(irq), 32'h0);
    rd_chk(OFS_RUNS, 32'h1);
    // slow memory with one corrupted word, only the mismatch unmasked
    slow <= 1'b1;
    bad_en <= 1'b1;
    apb(1'b1, OFS_IRQ_MASK, 32'h2);
    press();
    wait_done();
    check(32'(leds[1:0]), 32'h1);
    rd_chk(OFS_STATUS, 32'h2C);
    rd_chk(OFS_ERR_ADDR, 32'h5);
    rd_chk(OFS_IRQ_STAT, 32'h3);
    @(negedge clk);
    check(32'(irq), 32'h1);
    apb(1'b1, OFS_IRQ_STAT, 32'h2);
    @(negedge clk);
    check(32'(irq), 32'h0);
    rd_chk(OFS_IRQ_STAT, 32'h1);
    // a fresh clean run must clear the old failure
    bad_en <= 1'b0;
    press();
    wait_done();
    check(32'(leds[1:0]), 32'h2);
    rd_chk(OFS_RUNS, 32'h3);
    // software start, then continuous mode stopped during its first rerun
    apb(1'b1, OFS_CTRL, 32'h1);
    wait_done();
    rd_chk(OFS_RUNS, 32'h4);
    apb(1'b1, OFS_CTRL, 32'h2);
    rd_chk(OFS_CTRL, 32'h2);
    apb(1'b1, OFS_CTRL, 32'h0);
    wait_done();
    check(32'(leds[1:0]), 32'h2);
    rd_chk(OFS_RUNS, 32'h5);
    print_verdict();
  end
endmodule : sdram_pattern_tester_test

`default_nettype wire

//--- sdt_blinker.sv
// sdt_blinker: free-running square wave for the indicators
`default_nettype none

module sdt_blinker #(
  parameter int unsigned HALF_CYC = sdt_pkg::BLINK_HALF_CYC
) (
  input  wire logic i_clock,
  input  wire logic i_srst,
  output var  logic o_blink
);

  localparam int unsigned CNT_W = (HALF_CYC > 1) ? $clog2(HALF_CYC) : 1;
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(HALF_CYC - 1);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             blink;
  } sdt_blink_t;

  sdt_blink_t st_r;
  sdt_blink_t st_nxt;

  // no start or stop input: only i_srst or a stopped clock can freeze it
  always_comb begin
    st_nxt = st_r;
    if (st_r.cnt == CNT_LAST) begin
      st_nxt.cnt   = '0;
      st_nxt.blink = ~st_r.blink;
    end else begin
      st_nxt.cnt = st_r.cnt + 1'b1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_blink = st_r.blink;

  a_beat_toggles : assert property (
    @(posedge i_clock) disable iff (i_srst)
    (st_r.cnt == CNT_LAST) |=> (o_blink != $past(o_blink))
  ) else $error("heartbeat failed to toggle");

endmodule : sdt_blinker

`default_nettype wire

//--- sdt_mem_model.sv
// sdt_mem_model: behavioural sdram controller on the tester's memory port
`default_nettype none

module sdt_mem_model
  import sdt_pkg::*;
#(
  parameter int unsigned WORDS = 16
) (
  input  wire logic                  i_clock,
  input  wire logic                  i_srst,
  input  wire logic                  i_slow,
  input  wire logic                  i_bad_en,
  input  wire logic [ADDR_W-1:0]     i_bad_addr,
  input  wire sdt_pkg::sdt_mem_req_t i_req,
  output var  logic                  o_ready,
  output var  sdt_pkg::sdt_mem_rsp_t o_rsp
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [DATA_W-1:0] mem [WORDS];
  logic [DATA_W-1:0] rd_q [$];
  logic [DATA_W-1:0] last_r;
  logic              ph_r;
  int                writes;
  int                reads;

  ////////////////////////////////////////////////////////////////////////////
  // slow mode stalls every other cycle, both accepting and returning
  assign o_ready = !(i_slow && ph_r);

  always @(posedge i_clock) begin
    if (i_srst) begin
      ph_r   <= 1'b0;
      last_r <= '0;
      o_rsp  <= '0;
      rd_q.delete();
      writes = 0;
      reads  = 0;
    end else begin
      ph_r         <= ~ph_r;
      if (i_req.req && o_ready) begin
        if (i_req.we) begin
          mem[i_req.addr % WORDS] <= i_req.wdata;
          writes++;
        end else begin
          // one word may be corrupted on command, to model a bad cell
          rd_q.push_back(mem[i_req.addr % WORDS] ^
            {DATA_W{i_bad_en && (i_req.addr == i_bad_addr)}});
          reads++;
        end
      end
      if ((rd_q.size() > 0) && o_ready) begin
        last_r       <= rd_q[0];
        o_rsp.rvalid <= 1'b1;
        o_rsp.rdata  <= rd_q.pop_front();
      end else begin
        o_rsp.rvalid <= 1'b0;
        // idle data bus shows garbage, never the last word returned
        o_rsp.rdata  <= ~last_r;
      end
    end
  end
endmodule : sdt_mem_model

`default_nettype wire

//--- sdt_pattern_gen.sv
// sdt_pattern_gen: address-keyed test word, regenerated rather than stored
`default_nettype none

module sdt_pattern_gen
  import sdt_pkg::*;
(
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [DATA_W-1:0] i_seed,
  output var  logic [DATA_W-1:0] o_data
);

  // mixing high address bits down makes aliased rows show as mismatches
  always_comb begin
    o_data = i_addr[15:0] ^ {i_addr[8:0], i_addr[24:18]} ^ i_seed;
  end

endmodule : sdt_pattern_gen

`default_nettype wire

//--- sdt_pkg.sv
// sdt_pkg: constants and carrier types of the sdram pattern tester
`default_nettype none

package sdt_pkg;

  localparam int unsigned CLK_HZ         = 20_000_000;
  localparam int unsigned REF_CLK_HZ     = 50_000_000;
  localparam int unsigned MEM_CLK_HZ     = 100_000_000;
  localparam int unsigned MEM_CLK_MUL    = MEM_CLK_HZ / REF_CLK_HZ;
  localparam int unsigned MEM_BYTES      = 64 * 1024 * 1024;
  localparam int unsigned WORD_BYTES     = 2;
  localparam int unsigned MEM_WORDS      = MEM_BYTES / WORD_BYTES;
  localparam int unsigned ADDR_W         = 25;
  localparam int unsigned DATA_W         = 16;
  localparam int unsigned BLINK_HALF_MS  = 250;
  localparam int unsigned BLINK_HALF_CYC = CLK_HZ / 1000 * BLINK_HALF_MS;

  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_STATUS   = 8'h04;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
  localparam logic [7:0] OFS_SEED     = 8'h10;
  localparam logic [7:0] OFS_ERR_ADDR = 8'h14;
  localparam logic [7:0] OFS_RUNS     = 8'h18;

  localparam int unsigned CTRL_START_BIT   = 0;
  localparam int unsigned CTRL_CONT_BIT    = 1;
  localparam int unsigned IRQ_DONE_BIT     = 0;
  localparam int unsigned IRQ_MISMATCH_BIT = 1;
  localparam int unsigned IRQ_W            = 2;
  localparam int unsigned LED_FAIL_BIT     = 0;
  localparam int unsigned LED_PASS_BIT     = 1;
  localparam int unsigned LED_BEAT_BIT     = 2;

  localparam logic [DATA_W-1:0] SEED_RST = 16'h5A3C;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_HOLD   = 3'b001,
    ST_FILL   = 3'b010,
    ST_VERIFY = 3'b011,
    ST_DONE   = 3'b100
  } sdt_fsm_t;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [7:0]        paddr;
    logic [31:0]       pwdata;
  } sdt_apb_req_t;

  typedef struct packed {
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
  } sdt_apb_rsp_t;

  typedef struct packed {
    logic              req;
    logic              we;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } sdt_mem_req_t;

  typedef struct packed {
    logic              rvalid;
    logic [DATA_W-1:0] rdata;
  } sdt_mem_rsp_t;

  typedef struct packed {
    sdt_fsm_t          fsm;
    logic              btn_q;
    logic              fail;
    logic              cont;
    logic              all_issued;
    logic [ADDR_W-1:0] issue;
    logic [ADDR_W-1:0] cmp;
    sdt_mem_req_t      mreq;
    logic [2:0]        leds;
    logic [IRQ_W-1:0]  irq_stat;
    logic [IRQ_W-1:0]  irq_mask;
    logic [DATA_W-1:0] seed;
    logic [ADDR_W-1:0] err_addr;
    logic [15:0]       runs;
    logic [31:0]       prdata;
    logic              pslverr;
  } sdt_state_t;

  localparam sdt_state_t STATE_RST = '{
    fsm: ST_IDLE, seed: SEED_RST, default: '0
  };

endpackage : sdt_pkg

`default_nettype wire

//--- sdt_tester.sv
// sdt_tester: apb-controlled sdram fill and verify engine with indicators
//
// Register access over APB and the address map were left to the implementer.
`default_nettype none

module sdt_tester #(
  parameter int unsigned TEST_WORDS = sdt_pkg::MEM_WORDS,
  parameter int unsigned BLINK_CYC  = sdt_pkg::BLINK_HALF_CYC
) (
  input  wire logic                  I_CLOCK,
  input  wire logic                  I_SRST,
  input  wire logic                  I_START_BUTTON_N,
  input  wire sdt_pkg::sdt_apb_req_t I_APB,
  output var  sdt_pkg::sdt_apb_rsp_t O_APB,
  input  wire logic                  I_MEM_CLK_LOCKED,
  output var  sdt_pkg::sdt_mem_req_t O_MEM_REQ,
  input  wire logic                  I_MEM_READY,
  input  wire sdt_pkg::sdt_mem_rsp_t I_MEM_RSP,
  output var  logic [2:0]            O_RED_INDICATORS,
  output var  logic                  O_IRQ
);

  import sdt_pkg::*;

  localparam logic [ADDR_W-1:0] LAST = ADDR_W'(TEST_WORDS - 1);

  ////////////////////////////////////////////////////////////////////////////
  // state and helpers

  sdt_state_t        st_r;
  sdt_state_t        st_nxt;
  logic [DATA_W-1:0] pat_issue;
  logic [DATA_W-1:0] pat_cmp;
  logic              blink;
  logic              pressed;
  logic              released;
  logic              apb_setup;
  logic              apb_wr;
  logic              start_wr;
  logic              accepted;
  logic              can_issue;
  logic              mismatch;
  logic [31:0]       rdata;
  logic              unmapped;
  logic [IRQ_W-1:0]  irq_set;
  logic [IRQ_W-1:0]  irq_clr;

  assign pressed   = ~I_START_BUTTON_N;
  assign released  = st_r.btn_q & ~pressed;
  assign apb_setup = I_APB.psel & ~I_APB.penable;
  assign apb_wr    = I_APB.psel & I_APB.penable & I_APB.pwrite;
  assign start_wr  = apb_wr & (I_APB.paddr == OFS_CTRL)
                   & I_APB.pwdata[CTRL_START_BIT];
  assign accepted  = st_r.mreq.req & I_MEM_READY;

  // a request stays put until taken, so lock only gates new issues
  assign can_issue = (~st_r.mreq.req | I_MEM_READY) & I_MEM_CLK_LOCKED
                   & ~st_r.all_issued
                   & ((st_r.fsm == ST_FILL) | (st_r.fsm == ST_VERIFY));

  assign mismatch  = (st_r.fsm == ST_VERIFY) & I_MEM_RSP.rvalid
                   & (I_MEM_RSP.rdata != pat_cmp);

  ////////////////////////////////////////////////////////////////////////////
  // sub-blocks

  sdt_pattern_gen u_gen_issue (
    .i_addr (st_r.issue),
    .i_seed (st_r.seed),
    .o_data (pat_issue)
  );

  sdt_pattern_gen u_gen_cmp (
    .i_addr (st_r.cmp),
    .i_seed (st_r.seed),
    .o_data (pat_cmp)
  );

  sdt_blinker #(
    .HALF_CYC (BLINK_CYC)
  ) u_blinker (
    .i_clock (I_CLOCK),
    .i_srst  (I_SRST),
    .o_blink (blink)
  );

  ////////////////////////////////////////////////////////////////////////////
  // register read mux

  always_comb begin
    rdata    = 32'h0000_0000;
    unmapped = 1'b0;
    case (I_APB.paddr)
      OFS_CTRL: begin
        rdata[CTRL_CONT_BIT] = st_r.cont;
      end
      OFS_STATUS: begin
        rdata = {25'h0, st_r.btn_q, I_MEM_CLK_LOCKED,
                 (st_r.fsm == ST_DONE) & ~st_r.fail, st_r.fail, st_r.fsm};
      end
      OFS_IRQ_STAT: begin
        rdata = {30'h0, st_r.irq_stat};
      end
      OFS_IRQ_MASK: begin
        rdata = {30'h0, st_r.irq_mask};
      end
      OFS_SEED: begin
        rdata = {16'h0, st_r.seed};
      end
      OFS_ERR_ADDR: begin
        rdata = {7'h0, st_r.err_addr};
      end
      OFS_RUNS: begin
        rdata = {16'h0, st_r.runs};
      end
      default: begin
        unmapped = 1'b1;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    st_nxt       = st_r;
    irq_set      = '0;
    irq_clr      = '0;
    st_nxt.btn_q = pressed;

    // memory request handshake
    if (can_issue) begin
      st_nxt.mreq.req   = 1'b1;
      st_nxt.mreq.we    = (st_r.fsm == ST_FILL);
      st_nxt.mreq.addr  = st_r.issue;
      st_nxt.mreq.wdata = pat_issue;
      st_nxt.issue      = st_r.issue + 1'b1;
      if (st_r.issue == LAST) begin
        st_nxt.all_issued = 1'b1;
      end
    end else if (accepted) begin
      st_nxt.mreq.req = 1'b0;
    end

    case (st_r.fsm)
      ST_IDLE: begin
        st_nxt.fsm = ST_IDLE;
      end
      ST_HOLD: begin
        if (released) begin
          st_nxt.fsm = ST_FILL;
        end
      end
      ST_FILL: begin
        // every word written before the first read goes out
        if (st_r.all_issued && !st_r.mreq.req) begin
          st_nxt.fsm        = ST_VERIFY;
          st_nxt.issue      = '0;
          st_nxt.all_issued = 1'b0;
          st_nxt.cmp        = '0;
        end
      end
      ST_VERIFY: begin
        // reads return in issue order, so a counter tracks the compare
        if (I_MEM_RSP.rvalid) begin
          st_nxt.cmp = st_r.cmp + 1'b1;
          if (mismatch && !st_r.fail) begin
            st_nxt.fail     = 1'b1;
            st_nxt.err_addr = st_r.cmp;
            irq_set[IRQ_MISMATCH_BIT] = 1'b1;
          end
          if (st_r.cmp == LAST) begin
            st_nxt.fsm  = ST_DONE;
            st_nxt.runs = st_r.runs + 1'b1;
            irq_set[IRQ_DONE_BIT] = 1'b1;
          end
        end
      end
      ST_DONE: begin
        if (st_r.cont) begin
          st_nxt.fsm        = ST_FILL;
          st_nxt.fail       = 1'b0;
          st_nxt.issue      = '0;
          st_nxt.all_issued = 1'b0;
        end
      end
      default: begin
        st_nxt.fsm = ST_IDLE;
      end
    endcase

    // a software start behaves like press and release in one
    if (start_wr && st_r.fsm != ST_HOLD) begin
      st_nxt.fsm        = ST_FILL;
      st_nxt.fail       = 1'b0;
      st_nxt.issue      = '0;
      st_nxt.all_issued = 1'b0;
      st_nxt.mreq.req   = 1'b0;
    end

    // the button overrides the run state and a software start, and abandons a run in flight
    if (pressed) begin
      st_nxt.fsm        = ST_HOLD;
      st_nxt.fail       = 1'b0;
      st_nxt.issue      = '0;
      st_nxt.all_issued = 1'b0;
      st_nxt.cmp        = '0;
      st_nxt.mreq.req   = 1'b0;
    end

    // apb: answer is prepared in setup so the access phase needs no wait
    if (apb_setup) begin
      st_nxt.prdata  = I_APB.pwrite ? 32'h0000_0000 : rdata;
      st_nxt.pslverr = unmapped;
    end
    if (apb_wr) begin
      case (I_APB.paddr)
        OFS_CTRL: begin
          st_nxt.cont = I_APB.pwdata[CTRL_CONT_BIT];
        end
        OFS_IRQ_STAT: begin
          irq_clr = I_APB.pwdata[IRQ_W-1:0];
        end
        OFS_IRQ_MASK: begin
          st_nxt.irq_mask = I_APB.pwdata[IRQ_W-1:0];
        end
        OFS_SEED: begin
          st_nxt.seed = I_APB.pwdata[DATA_W-1:0];
        end
        default: begin
          st_nxt.cont = st_r.cont;
        end
      endcase
    end
    // set beats a clear landing in the same cycle
    st_nxt.irq_stat = (st_r.irq_stat & ~irq_clr) | irq_set;

    // indicators follow the state being entered
    case (st_nxt.fsm)
      ST_HOLD: begin
        st_nxt.leds = 3'h7;
      end
      ST_FILL, ST_VERIFY: begin
        st_nxt.leds = {blink, blink, st_nxt.fail};
      end
      ST_DONE: begin
        st_nxt.leds = {blink, ~st_nxt.fail, st_nxt.fail};
      end
      default: begin
        st_nxt.leds = {blink, 2'b00};
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register and outputs

  always_ff @(posedge I_CLOCK) begin
    if (I_SRST) begin
      st_r <= STATE_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign O_APB            = '{prdata: st_r.prdata, pready: 1'b1,
                              pslverr: st_r.pslverr};
  assign O_MEM_REQ        = st_r.mreq;
  assign O_RED_INDICATORS = st_r.leds;
  assign O_IRQ            = |(st_r.irq_stat & st_r.irq_mask);

  ////////////////////////////////////////////////////////////////////////////
  // checks

  int unsigned wr_count;

  always_ff @(posedge I_CLOCK) begin
    if (I_SRST || st_r.fsm != ST_FILL) begin
      wr_count <= 0;
    end else if (accepted) begin
      wr_count <= wr_count + 1;
    end
  end

  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (I_SRST);

  sequence s_press;
    pressed;
  endsequence

  sequence s_release_in_hold;
    released && st_r.fsm == ST_HOLD;
  endsequence

  sequence s_fill_to_verify;
    st_r.fsm == ST_FILL ##1 st_r.fsm == ST_VERIFY;
  endsequence

  a_req_locked : assert property (
    $rose(O_MEM_REQ.req) |-> $past(I_MEM_CLK_LOCKED)
  ) else $error("request issued without memory clock lock");

  a_fill_writes : assert property (
    (st_r.fsm == ST_FILL && O_MEM_REQ.req) |-> O_MEM_REQ.we
  ) else $error("non-write request during fill");

  a_verify_reads : assert property (
    (st_r.fsm == ST_VERIFY && O_MEM_REQ.req) |-> !O_MEM_REQ.we
  ) else $error("write request during verify");

  a_full_range : assert property (
    s_fill_to_verify |-> ($past(wr_count) == TEST_WORDS)
  ) else $error("fill did not cover every word");

  a_hold_lit : assert property (
    s_press |=> (O_RED_INDICATORS == 3'h7)
  ) else $error("indicators not all lit while button held");

  a_release_run : assert property (
    s_release_in_hold |=> (st_r.fsm == ST_FILL)
  ) else $error("release did not start the fill");

  a_pass_steady : assert property (
    (st_r.fsm == ST_DONE && !st_r.fail)[*3]
      |-> O_RED_INDICATORS[LED_PASS_BIT]
  ) else $error("pass indicator not steady after clean run");

  a_fail_dark : assert property (
    (st_r.fsm == ST_DONE && st_r.fail)
      |-> (!O_RED_INDICATORS[LED_PASS_BIT]
           && O_RED_INDICATORS[LED_FAIL_BIT])
  ) else $error("pass indicator lit after a mismatch");

  a_restart_clear : assert property (
    s_press |=> (st_r.fsm == ST_HOLD && !st_r.fail && !O_MEM_REQ.req)
  ) else $error("press did not clear the previous result");

  a_mismatch_latch : assert property (
    (mismatch && !pressed && !start_wr) |=> st_r.fail
  ) else $error("mismatch did not set the failure flag");

  a_fail_sticky : assert property (
    (st_r.fail && !pressed && !start_wr && !st_r.cont) |=> st_r.fail
  ) else $error("failure flag dropped without a new start");

  a_done_irq : assert property (
    $rose(st_r.fsm == ST_DONE) |-> st_r.irq_stat[IRQ_DONE_BIT]
  ) else $error("done event not recorded");

endmodule : sdt_tester

`default_nettype wire
